// file: bmc_pkg.sv
/*
 bmc_pkg: constants for the bus management resource block.
 assumes: a single 125 MHz system clock, host registers at byte offsets.
*/
package bmc_pkg;
   // host register byte offsets
   localparam logic [7:0] BMC_OFF_SWAP_DATA = 8'h0C;
   localparam logic [7:0] BMC_OFF_SWAP_EXPECTED = 8'h10;
   localparam logic [7:0] BMC_OFF_SWAP_CONTROL = 8'h14;
   localparam logic [7:0] BMC_OFF_ROM_HEADER = 8'h18;
   localparam logic [7:0] BMC_OFF_BUS_IDENT = 8'h1C;
   // field positions in the control register
   localparam int BMC_DONE_BIT = 31;
   localparam int BMC_SEL_LSB = 0;
   localparam int BMC_SEL_W = 2;
   // reset values and the bus identification constant
   localparam logic [31:0] BMC_RST_BUS_MGR_ID = 32'h0000_003F;
   localparam logic [31:0] BMC_RST_BANDWIDTH = 32'h0000_1333;
   localparam logic [31:0] BMC_RST_CHANNELS = 32'hFFFF_FFFF;
   localparam logic [31:0] BMC_RST_ROM_HEADER = 32'h0000_0000;
   localparam logic [31:0] BMC_BUS_IDENT_VALUE = 32'h3133_3934;
   // 1394 CSR addresses, low 32 bits (high 16 bits are FFFFh)
   localparam logic [15:0] BMC_CSR_ADDR_HI = 16'hFFFF;
   localparam logic [31:0] BMC_CSR_RES_BASE = 32'hF000_021C;
   localparam logic [31:0] BMC_CSR_RES_LAST = 32'hF000_0228;
   localparam logic [31:0] BMC_CSR_BUS_INFO = 32'hF000_0404;
   localparam logic [31:0] BMC_CSR_ROM_BASE = 32'hF000_0400;
   localparam logic [31:0] BMC_CSR_ROM_LAST = 32'hF000_07FC;
   // bus transaction codes
   localparam logic [3:0] BMC_TC_QREAD = 4'h4;
   localparam logic [3:0] BMC_TC_LOCK = 4'h9;
   // acknowledge codes
   localparam logic [3:0] BMC_ACK_COMPLETE = 4'h1;
   localparam logic [3:0] BMC_ACK_PENDING = 4'h2;
   localparam logic [3:0] BMC_ACK_TYPE_ERROR = 4'hE;
   localparam logic [3:0] BMC_ACK_ADDR_ERROR = 4'hF;
   typedef enum logic [1:0] {
      BMC_SEL_BUS_MGR,
      BMC_SEL_BANDWIDTH,
      BMC_SEL_CHAN_HI,
      BMC_SEL_CHAN_LO
   } bmc_sel_t;
endpackage : bmc_pkg

// file: bmc_cas_unit.sv
/*
 bmc_cas_unit: the four management resources and one compare-and-swap port.
 assumes: the caller arbitrates, so at most one request per cycle arrives.
*/
`timescale 1ns/1ps
module bmc_cas_unit
   import bmc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic bus_reset_in,
   input wire logic req_in,
   input wire bmc_pkg::bmc_sel_t sel_in,
   input wire logic [31:0] expected_in,
   input wire logic [31:0] new_in,
   input wire bmc_pkg::bmc_sel_t rd_sel_in,
   output logic [31:0] prior_out,
   output logic [31:0] rd_data_out
);
   import bmc_pkg::*;

   logic [31:0] res_q [4];
   logic [31:0] res_d [4];

   function automatic logic [31:0] reset_value(input int idx);
      reset_value = (idx == 0) ? BMC_RST_BUS_MGR_ID :
                    (idx == 1) ? BMC_RST_BANDWIDTH : BMC_RST_CHANNELS;
   endfunction : reset_value

   // prior value read combinationally in the swap cycle itself
   assign prior_out = res_q[sel_in];
   assign rd_data_out = res_q[rd_sel_in];

   ////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_res
         // only a matching compare or a bus reset writes; no other write path exists
         always_comb begin
            res_d[gi] = res_q[gi];
            if (bus_reset_in) begin
               res_d[gi] = reset_value(gi);
            end else if (req_in && (sel_in == bmc_sel_t'(gi))
                         && (res_q[gi] == expected_in)) begin
               res_d[gi] = new_in;
            end
         end
         // resources live here so each swap is one atomic cycle
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               res_q[gi] <= reset_value(gi);
            end else begin
               res_q[gi] <= res_d[gi];
            end
         end
      end
   endgenerate
endmodule : bmc_cas_unit

// file: bmc_top.sv
/*
 bmc_top: host registers, bus-side request service and config ROM replies
 for the serial bus management resources.
 assumes: the host register port is a simple one-cycle strobe interface,
 the link engine presents one bus request at a time with a ready handshake.
*/
// Functional notes
// - bus accepts only quadlet read and lock
// - bus locks executed fully in hardware
// - unacknowledged lock reply raises failure event
// - control write starts swap on selector
// - done sets, data gets prior value
// - done reads one at reset, write clears
// - resources change only by swap
// - selector codes pick the four resources
// - resources reset on hardware or bus reset
// - resources respond at fixed CSR addresses
// - ROM header, bus info, ROM served automatically
// - ROM header register answers ROM address
// - ROM header fields, zero at reset
// - bus identification constant, first info quadlet
// - resources kept inside for atomic access
`timescale 1ns/1ps
module bmc_top
#(
   parameter int ROM_WORDS = 256
)
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   input wire logic BUS_RESET_IN,
   // host register port
   input wire logic HOST_WR_IN,
   input wire logic HOST_RD_IN,
   input wire logic [7:0] HOST_ADDR_IN,
   input wire logic [31:0] HOST_WDATA_IN,
   output logic [31:0] HOST_RDATA_OUT,
   output logic HOST_ADDR_ERR_OUT,
   // bus request from the link engine
   input wire logic REQ_VALID_IN,
   output logic REQ_READY_OUT,
   input wire logic [3:0] REQ_TCODE_IN,
   input wire logic [47:0] REQ_ADDR_IN,
   input wire logic [31:0] REQ_ARG_IN,
   input wire logic [31:0] REQ_DATA_IN,
   output logic ACK_VALID_OUT,
   output logic [3:0] ACK_CODE_OUT,
   output logic RESP_VALID_OUT,
   output logic [31:0] RESP_DATA_OUT,
   // ROM fetch for the rest of the first kilobyte
   output logic ROM_RD_OUT,
   output logic [7:0] ROM_INDEX_OUT,
   input wire logic [31:0] ROM_DATA_IN,
   // final ack of a lock reply, seen from the link engine
   input wire logic LOCK_ACK_VALID_IN,
   input wire logic [3:0] LOCK_ACK_CODE_IN,
   output logic LOCK_REPLY_FAILURE_EVENT_OUT,
   output logic SWAP_DONE_FLAG_OUT
);
   import bmc_pkg::*;

   if (ROM_WORDS < 2 || ROM_WORDS > 256) begin : g_rom_words_check
      $error("ROM_WORDS must be within 2..256");
   end
   // classification of a bus CSR address, used by read and lock paths
   typedef enum logic [2:0] {
      BMC_AC_RES, BMC_AC_HDR, BMC_AC_INFO, BMC_AC_ROM, BMC_AC_NONE
   } bmc_aclass_t;

   function automatic bmc_aclass_t addr_class(input logic [47:0] a);
      addr_class = BMC_AC_NONE;
      if (a[47:32] == BMC_CSR_ADDR_HI && a[1:0] == 2'b00) begin
         if (a[31:0] >= BMC_CSR_RES_BASE && a[31:0] <= BMC_CSR_RES_LAST) begin
            addr_class = BMC_AC_RES;
         end else if (a[31:0] == BMC_CSR_ROM_BASE) begin
            addr_class = BMC_AC_HDR;
         end else if (a[31:0] == BMC_CSR_BUS_INFO) begin
            addr_class = BMC_AC_INFO;
         end else if (a[31:10] == BMC_CSR_ROM_BASE[31:10] && a[9:2] < ROM_WORDS) begin
            addr_class = BMC_AC_ROM;
         end
      end
   endfunction : addr_class
   function automatic bmc_sel_t res_sel(input logic [47:0] a);
      logic [31:0] off;
      off = a[31:0] - BMC_CSR_RES_BASE;
      res_sel = bmc_sel_t'(off[3:2]);
   endfunction : res_sel
   ////////////////////////////////////////////////////////////////////
   // synchronise the asynchronous bus-reset input
   logic bus_rst_meta_q;
   logic bus_rst_q;
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         bus_rst_meta_q <= 1'b0;
         bus_rst_q <= 1'b0;
      end else begin
         bus_rst_meta_q <= BUS_RESET_IN;
         bus_rst_q <= bus_rst_meta_q;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // host registers and host swap sequencing
   logic [31:0] swap_data_value_q, swap_data_value_d;
   logic [31:0] swap_expected_value_q, swap_expected_value_d;
   bmc_sel_t resource_selector_q, resource_selector_d;
   logic swap_done_flag_q, swap_done_flag_d;
   logic host_pend_q, host_pend_d;
   logic [31:0] rom_header_quadlet_q, rom_header_quadlet_d;
   logic [31:0] host_rdata_q, host_rdata_d;
   logic host_err_q, host_err_d;

   // bus side request path
   typedef enum logic [1:0] {BMC_ST_IDLE, BMC_ST_ROM, BMC_ST_WAIT} bmc_state_t;
   bmc_state_t st_q, st_d;
   logic ack_v_q, ack_v_d;
   logic [3:0] ack_c_q, ack_c_d;
   logic resp_v_q, resp_v_d;
   logic [31:0] resp_d_q, resp_d_d;
   logic rom_rd_q, rom_rd_d;
   logic [7:0] rom_idx_q, rom_idx_d;
   logic fail_q, fail_d;

   // shared swap port
   logic cas_req;
   bmc_sel_t cas_sel;
   logic [31:0] cas_exp;
   logic [31:0] cas_new;
   logic [31:0] cas_prior;
   logic [31:0] res_rd;
   logic bus_lock;
   logic host_go;
   bmc_aclass_t req_cls;
   assign req_cls = addr_class(REQ_ADDR_IN);
   assign bus_lock = REQ_VALID_IN && REQ_READY_OUT && REQ_TCODE_IN == BMC_TC_LOCK
                     && req_cls == BMC_AC_RES;
   // bus lock wins; the host swap simply waits a cycle
   assign host_go = host_pend_q && !bus_lock;
   // one port into the resources serialises both requesters
   always_comb begin
      cas_req = bus_lock || host_go;
      cas_sel = bus_lock ? res_sel(REQ_ADDR_IN) : resource_selector_q;
      cas_exp = bus_lock ? REQ_ARG_IN : swap_expected_value_q;
      cas_new = bus_lock ? REQ_DATA_IN : swap_data_value_q;
   end

   bmc_cas_unit u_cas (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(RST_N_IN),
      .bus_reset_in(bus_rst_q),
      .req_in(cas_req),
      .sel_in(cas_sel),
      .expected_in(cas_exp),
      .new_in(cas_new),
      .rd_sel_in(res_sel(REQ_ADDR_IN)),
      .prior_out(cas_prior),
      .rd_data_out(res_rd)
   );
   ////////////////////////////////////////////////////////////////////
   // host register writes, reads and completion of the host swap
   always_comb begin
      swap_data_value_d = swap_data_value_q;
      swap_expected_value_d = swap_expected_value_q;
      resource_selector_d = resource_selector_q;
      swap_done_flag_d = swap_done_flag_q;
      host_pend_d = host_pend_q;
      rom_header_quadlet_d = rom_header_quadlet_q;
      host_rdata_d = host_rdata_q;
      host_err_d = 1'b0;
      if (host_go) begin
         swap_data_value_d = cas_prior;
         swap_done_flag_d = 1'b1;
         host_pend_d = 1'b0;
      end
      if (HOST_WR_IN) begin
         unique case (HOST_ADDR_IN)
            BMC_OFF_SWAP_DATA: swap_data_value_d = HOST_WDATA_IN;
            BMC_OFF_SWAP_EXPECTED: swap_expected_value_d = HOST_WDATA_IN;
            BMC_OFF_SWAP_CONTROL: begin
               // a fresh start replaces a pending one held back by a bus lock; any other pending one still runs this cycle
               resource_selector_d =
                  bmc_sel_t'(HOST_WDATA_IN[BMC_SEL_LSB +: BMC_SEL_W]);
               swap_done_flag_d = 1'b0;
               host_pend_d = 1'b1;
            end
            BMC_OFF_ROM_HEADER: rom_header_quadlet_d = HOST_WDATA_IN;
            BMC_OFF_BUS_IDENT: ;
            default: host_err_d = 1'b1;
         endcase
      end
      if (HOST_RD_IN) begin
         unique case (HOST_ADDR_IN)
            BMC_OFF_SWAP_DATA: host_rdata_d = swap_data_value_q;
            BMC_OFF_SWAP_EXPECTED: host_rdata_d = swap_expected_value_q;
            BMC_OFF_SWAP_CONTROL: begin
               host_rdata_d = 32'h0000_0000;
               host_rdata_d[BMC_DONE_BIT] = swap_done_flag_q;
               host_rdata_d[BMC_SEL_LSB +: BMC_SEL_W] = resource_selector_q;
            end
            BMC_OFF_ROM_HEADER: host_rdata_d = rom_header_quadlet_q;
            BMC_OFF_BUS_IDENT: host_rdata_d = BMC_BUS_IDENT_VALUE;
            default: begin
               host_rdata_d = 32'h0000_0000;
               host_err_d = 1'b1;
            end
         endcase
      end
   end
   // data registers have no documented reset; zero keeps them defined
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         swap_data_value_q <= 32'h0000_0000;
         swap_expected_value_q <= 32'h0000_0000;
         resource_selector_q <= BMC_SEL_BUS_MGR;
         swap_done_flag_q <= 1'b1;
         host_pend_q <= 1'b0;
         rom_header_quadlet_q <= BMC_RST_ROM_HEADER;
         host_rdata_q <= 32'h0000_0000;
         host_err_q <= 1'b0;
      end else begin
         swap_data_value_q <= swap_data_value_d;
         swap_expected_value_q <= swap_expected_value_d;
         resource_selector_q <= resource_selector_d;
         swap_done_flag_q <= swap_done_flag_d;
         host_pend_q <= host_pend_d;
         rom_header_quadlet_q <= rom_header_quadlet_d;
         host_rdata_q <= host_rdata_d;
         host_err_q <= host_err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus request service: ack next cycle, reply with it or after ROM fetch
   always_comb begin
      st_d = st_q;
      ack_v_d = 1'b0;
      ack_c_d = ack_c_q;
      resp_v_d = 1'b0;
      resp_d_d = resp_d_q;
      rom_rd_d = 1'b0;
      rom_idx_d = rom_idx_q;
      fail_d = 1'b0;
      unique case (st_q)
         BMC_ST_IDLE: begin
            if (REQ_VALID_IN) begin
               ack_v_d = 1'b1;
               if (req_cls == BMC_AC_NONE) begin
                  ack_c_d = BMC_ACK_ADDR_ERROR;
               end else if (REQ_TCODE_IN == BMC_TC_LOCK && req_cls == BMC_AC_RES) begin
                  ack_c_d = BMC_ACK_PENDING;
                  resp_v_d = 1'b1;
                  resp_d_d = cas_prior;
                  st_d = BMC_ST_WAIT;
               end else if (REQ_TCODE_IN != BMC_TC_QREAD) begin
                  ack_c_d = BMC_ACK_TYPE_ERROR;
               end else begin
                  ack_c_d = BMC_ACK_PENDING;
                  unique case (req_cls)
                     BMC_AC_RES: begin
                        resp_v_d = 1'b1;
                        resp_d_d = res_rd;
                     end
                     BMC_AC_HDR: begin
                        resp_v_d = 1'b1;
                        resp_d_d = rom_header_quadlet_q;
                     end
                     BMC_AC_INFO: begin
                        resp_v_d = 1'b1;
                        resp_d_d = BMC_BUS_IDENT_VALUE;
                     end
                     default: begin
                        // rest of the first kilobyte comes from the ROM store
                        rom_rd_d = 1'b1;
                        rom_idx_d = REQ_ADDR_IN[9:2];
                        st_d = BMC_ST_ROM;
                     end
                  endcase
               end
            end
         end
         BMC_ST_ROM: begin
            resp_v_d = 1'b1;
            resp_d_d = ROM_DATA_IN;
            st_d = BMC_ST_IDLE;
         end
         BMC_ST_WAIT: begin
            // stalls further requests until the reply is acknowledged
            if (LOCK_ACK_VALID_IN) begin
               fail_d = (LOCK_ACK_CODE_IN != BMC_ACK_COMPLETE);
               st_d = BMC_ST_IDLE;
            end
         end
         default: st_d = BMC_ST_IDLE;
      endcase
      if (bus_rst_q) begin
         st_d = BMC_ST_IDLE;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st_q <= BMC_ST_IDLE;
         ack_v_q <= 1'b0;
         ack_c_q <= 4'h0;
         resp_v_q <= 1'b0;
         resp_d_q <= 32'h0000_0000;
         rom_rd_q <= 1'b0;
         rom_idx_q <= 8'h00;
         fail_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ack_v_q <= ack_v_d;
         ack_c_q <= ack_c_d;
         resp_v_q <= resp_v_d;
         resp_d_q <= resp_d_d;
         rom_rd_q <= rom_rd_d;
         rom_idx_q <= rom_idx_d;
         fail_q <= fail_d;
      end
   end
   // ready follows the state alone, no register
   assign REQ_READY_OUT = (st_q == BMC_ST_IDLE);
   // outputs straight from registers
   assign HOST_RDATA_OUT = host_rdata_q;
   assign HOST_ADDR_ERR_OUT = host_err_q;
   assign ACK_VALID_OUT = ack_v_q;
   assign ACK_CODE_OUT = ack_c_q;
   assign RESP_VALID_OUT = resp_v_q;
   assign RESP_DATA_OUT = resp_d_q;
   assign ROM_RD_OUT = rom_rd_q;
   assign ROM_INDEX_OUT = rom_idx_q;
   assign LOCK_REPLY_FAILURE_EVENT_OUT = fail_q;
   assign SWAP_DONE_FLAG_OUT = swap_done_flag_q;
endmodule : bmc_top

// file: bmc_top_assertions.sv
/*
 bmc_top_assertions: port-level checks of bmc_top.
 assumes: bound to each bmc_top, one clock, reset active low.
*/
`timescale 1ns/1ps
module bmc_top_assertions
   import bmc_pkg::*;
#(
   parameter int ROM_WORDS = 256
)
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   input wire logic BUS_RESET_IN,
   input wire logic HOST_WR_IN,
   input wire logic HOST_RD_IN,
   input wire logic [7:0] HOST_ADDR_IN,
   input wire logic [31:0] HOST_WDATA_IN,
   input wire logic [31:0] HOST_RDATA_OUT,
   input wire logic HOST_ADDR_ERR_OUT,
   input wire logic REQ_VALID_IN,
   input wire logic REQ_READY_OUT,
   input wire logic [3:0] REQ_TCODE_IN,
   input wire logic [47:0] REQ_ADDR_IN,
   input wire logic [31:0] REQ_ARG_IN,
   input wire logic [31:0] REQ_DATA_IN,
   input wire logic ACK_VALID_OUT,
   input wire logic [3:0] ACK_CODE_OUT,
   input wire logic RESP_VALID_OUT,
   input wire logic [31:0] RESP_DATA_OUT,
   input wire logic ROM_RD_OUT,
   input wire logic [7:0] ROM_INDEX_OUT,
   input wire logic [31:0] ROM_DATA_IN,
   input wire logic LOCK_ACK_VALID_IN,
   input wire logic [3:0] LOCK_ACK_CODE_IN,
   input wire logic LOCK_REPLY_FAILURE_EVENT_OUT,
   input wire logic SWAP_DONE_FLAG_OUT
);
   //////////////////////////////////////////////////////////////////////////
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_N_IN);
   // request classes, decoded once so the properties stay short
   wire logic take = REQ_VALID_IN && REQ_READY_OUT;
   wire logic hi_ok = REQ_ADDR_IN[47:32] == BMC_CSR_ADDR_HI && REQ_ADDR_IN[1:0] == 2'h0;
   wire logic at_res = hi_ok && REQ_ADDR_IN[31:0] >= BMC_CSR_RES_BASE
      && REQ_ADDR_IN[31:0] <= BMC_CSR_RES_LAST;
   wire logic at_rom = hi_ok && REQ_ADDR_IN[31:0] >= 32'hF000_0408
      && REQ_ADDR_IN[31:0] <= BMC_CSR_ROM_LAST;
   wire logic ctl_wr = HOST_WR_IN && HOST_ADDR_IN == BMC_OFF_SWAP_CONTROL;
   wire logic bad_ack = LOCK_ACK_VALID_IN && !REQ_READY_OUT
      && LOCK_ACK_CODE_IN != BMC_ACK_COMPLETE;
   wire logic [7:0] rom_idx = REQ_ADDR_IN[9:2];
   //////////////////////////////////////////////////////////////////////////
   a_done_clear: assert property (ctl_wr |=> !SWAP_DONE_FLAG_OUT)
      else $error("done flag not cleared by control write");
   a_done_set: assert property (ctl_wr |-> ##[2:8] SWAP_DONE_FLAG_OUT)
      else $error("host swap never finished");
   a_ack_next: assert property (take |=> ACK_VALID_OUT)
      else $error("bus request without ack");
   a_type_err: assert property (take && at_res && REQ_TCODE_IN != BMC_TC_QREAD
      && REQ_TCODE_IN != BMC_TC_LOCK |=> ACK_CODE_OUT == BMC_ACK_TYPE_ERROR && !RESP_VALID_OUT)
      else $error("wrong answer to illegal transaction");
   a_lock_reply: assert property (take && at_res && REQ_TCODE_IN == BMC_TC_LOCK
      |=> RESP_VALID_OUT && ACK_CODE_OUT == BMC_ACK_PENDING && !REQ_READY_OUT)
      else $error("lock not answered by hardware");
   a_fail_pulse: assert property (bad_ack |=> LOCK_REPLY_FAILURE_EVENT_OUT
      ##1 !LOCK_REPLY_FAILURE_EVENT_OUT)
      else $error("failure event missing or too long");
   a_fail_quiet: assert property (!bad_ack |=> !LOCK_REPLY_FAILURE_EVENT_OUT)
      else $error("failure event without cause");
   a_ident_read: assert property (HOST_RD_IN && HOST_ADDR_IN == BMC_OFF_BUS_IDENT
      |=> HOST_RDATA_OUT == BMC_BUS_IDENT_VALUE)
      else $error("bus identification wrong");
   a_rom_fetch: assert property (take && at_rom && REQ_TCODE_IN == BMC_TC_QREAD
      |=> ROM_RD_OUT && ROM_INDEX_OUT == $past(rom_idx) ##1 RESP_VALID_OUT)
      else $error("rom read not served");
   // main scenarios reached
   c_host_swap: cover property (ctl_wr ##2 SWAP_DONE_FLAG_OUT);
   c_bus_lock: cover property (take && at_res && REQ_TCODE_IN == BMC_TC_LOCK);
   c_fail: cover property (LOCK_REPLY_FAILURE_EVENT_OUT);
endmodule : bmc_top_assertions

bind bmc_top bmc_top_assertions #(.ROM_WORDS(ROM_WORDS)) u_chk (.*);

// file: bmc_far_node.sv
/*
 bmc_far_node: remote node issuing one request at a time, acks lock replies.
 assumes: driven by task calls from the bench, shares the system clock.
*/
`timescale 1ns/1ps
module bmc_far_node (
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic ack_valid_in,
   input wire logic [3:0] ack_code_in,
   input wire logic resp_valid_in,
   input wire logic [31:0] resp_data_in,
   input wire logic fail_in,
   output logic valid_out = 1'b0,
   output logic [3:0] tcode_out = 4'h0,
   output logic [47:0] addr_out = 48'h0,
   output logic [31:0] arg_out = 32'h0,
   output logic [31:0] data_out = 32'h0,
   output logic lack_valid_out = 1'b0,
   output logic [3:0] lack_code_out = 4'h0
);
   //////////////////////////////////////////////////////////////////////////
   // one transfer; released address, argument and data lines flip so stale values never look valid
   task automatic xfer(input logic [3:0] tc, input logic [31:0] lo, a, d,
      input logic [3:0] lc, output logic [3:0] ack, output logic [31:0] rsp,
      output logic rv, fl, to);
      int n;
      logic ok;
      ok = 1'b0;
      rv = 1'b0;
      fl = 1'b0;
      rsp = 32'h0;
      ack = 4'h0;
      @(posedge clk_in);
      valid_out <= 1'b1;
      tcode_out <= tc;
      addr_out <= {16'hFFFF, lo};
      arg_out <= a;
      data_out <= d;
      for (n = 0; n < 20 && !ok; n++) begin
         @(negedge clk_in);
         ok = ready_in;
         @(posedge clk_in);
      end
      valid_out <= 1'b0;
      addr_out <= ~addr_out;
      arg_out <= ~arg_out;
      data_out <= ~data_out;
      to = !ok;
      for (n = 0; n < 4 && !rv; n++) begin
         @(negedge clk_in);
         if (ack_valid_in) ack = ack_code_in;
         if (resp_valid_in) begin
            rv = 1'b1;
            rsp = resp_data_in;
         end
      end
      // the ack that this node returns for the lock reply
      if (tc == 4'h9 && ack == 4'h2) begin
         @(posedge clk_in);
         lack_valid_out <= 1'b1;
         lack_code_out <= lc;
         @(posedge clk_in);
         lack_valid_out <= 1'b0;
         @(negedge clk_in);
         fl = fail_in;
      end
   endtask : xfer
endmodule : bmc_far_node

// file: testbench.sv
/*
 testbench: host and bus scenarios for bmc_top against an integer model.
 assumes: bmc_top_assertions is bound, combinational rom model below.
*/
`timescale 1ns/1ps
module testbench;
   import bmc_pkg::*;
   logic CLK_SYS_IN = 0, RST_N_IN = 0, BUS_RESET_IN = 0, HOST_WR_IN = 0, HOST_RD_IN = 0;
   logic [7:0] HOST_ADDR_IN = 0, ROM_INDEX_OUT;
   logic [31:0] HOST_WDATA_IN = 0, HOST_RDATA_OUT, RESP_DATA_OUT, ROM_DATA_IN;
   logic [31:0] REQ_ARG_IN, REQ_DATA_IN, mres[4], mdata, v, ev, nv;
   logic [47:0] REQ_ADDR_IN;
   logic [3:0] REQ_TCODE_IN, ACK_CODE_OUT, LOCK_ACK_CODE_IN;
   logic REQ_VALID_IN, REQ_READY_OUT, ACK_VALID_OUT, RESP_VALID_OUT, ROM_RD_OUT;
   logic HOST_ADDR_ERR_OUT, LOCK_ACK_VALID_IN, LOCK_REPLY_FAILURE_EVENT_OUT;
   logic SWAP_DONE_FLAG_OUT, e;
   int errors = 0, cmp_count = 0, seed = 83, i;
   //////////////////////////////////////////////////////////////////////////
   initial forever #4 CLK_SYS_IN = ~CLK_SYS_IN;
   // rom contents carry their own index so a wrong fetch shows
   assign ROM_DATA_IN = {24'hC3C3C3, ROM_INDEX_OUT};
   bmc_top dut (.*);
   bmc_far_node far (.clk_in(CLK_SYS_IN), .ready_in(REQ_READY_OUT),
      .ack_valid_in(ACK_VALID_OUT), .ack_code_in(ACK_CODE_OUT),
      .resp_valid_in(RESP_VALID_OUT), .resp_data_in(RESP_DATA_OUT),
      .fail_in(LOCK_REPLY_FAILURE_EVENT_OUT), .valid_out(REQ_VALID_IN),
      .tcode_out(REQ_TCODE_IN), .addr_out(REQ_ADDR_IN), .arg_out(REQ_ARG_IN),
      .data_out(REQ_DATA_IN), .lack_valid_out(LOCK_ACK_VALID_IN),
      .lack_code_out(LOCK_ACK_CODE_IN));
   //////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic hang;
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      give_verdict();
   endtask : hang
   task automatic chk(input logic [31:0] got, exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic hwrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS_IN);
      HOST_WR_IN <= 1'b1;
      HOST_ADDR_IN <= a;
      HOST_WDATA_IN <= d;
      @(posedge CLK_SYS_IN);
      HOST_WR_IN <= 1'b0;
   endtask : hwrite
   task automatic hread(input logic [7:0] a, output logic [31:0] d, output logic er);
      @(posedge CLK_SYS_IN);
      HOST_RD_IN <= 1'b1;
      HOST_ADDR_IN <= a;
      @(posedge CLK_SYS_IN);
      HOST_RD_IN <= 1'b0;
      @(negedge CLK_SYS_IN);
      d = HOST_RDATA_OUT;
      er = HOST_ADDR_ERR_OUT;
   endtask : hread
   task automatic bus(input logic [3:0] tc, input logic [31:0] lo, a, d,
      input logic [3:0] lc, eack, input logic [31:0] ersp, input logic erv, efl);
      logic [3:0] ack;
      logic [31:0] rsp;
      logic rv, fl, to;
      far.xfer(tc, lo, a, d, lc, ack, rsp, rv, fl, to);
      if (to) hang();
      chk(ack, eack, "ack code");
      chk(rv, erv, "response present");
      if (erv) chk(rsp, ersp, "response data");
      if (tc == BMC_TC_LOCK && erv) chk(fl, efl, "failure event");
   endtask : bus
   task automatic rdres(input logic [1:0] s);
      bus(BMC_TC_QREAD, BMC_CSR_RES_BASE + {s, 2'b00}, 0, 0, 0, BMC_ACK_PENDING, mres[s], 1, 0);
   endtask : rdres
   // host sequence: swap data, expected, then control
   task automatic hswap(input logic [1:0] s, input logic [31:0] n_v, e_v);
      int n;
      logic [31:0] d;
      logic er;
      hwrite(BMC_OFF_SWAP_DATA, n_v);
      hwrite(BMC_OFF_SWAP_EXPECTED, e_v);
      hwrite(BMC_OFF_SWAP_CONTROL, {30'h0, s});
      @(negedge CLK_SYS_IN);
      for (n = 0; n < 20 && SWAP_DONE_FLAG_OUT !== 1'b1; n++) @(negedge CLK_SYS_IN);
      if (n == 20) hang();
      mdata = mres[s];
      if (mres[s] === e_v) mres[s] = n_v;
      hread(BMC_OFF_SWAP_DATA, d, er);
      chk(d, mdata, "swap prior value");
      hread(BMC_OFF_SWAP_CONTROL, d, er);
      chk(d, {1'b1, 29'h0, s}, "control readback");
      rdres(s);
   endtask : hswap
   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge CLK_SYS_IN);
      RST_N_IN <= 1'b1;
      mres = '{BMC_RST_BUS_MGR_ID, BMC_RST_BANDWIDTH, BMC_RST_CHANNELS, BMC_RST_CHANNELS};
      hread(BMC_OFF_SWAP_CONTROL, v, e);
      chk(v[31], 1, "done after reset");
      hwrite(BMC_OFF_BUS_IDENT, 32'h0);
      hread(BMC_OFF_BUS_IDENT, v, e);
      chk(v, BMC_BUS_IDENT_VALUE, "bus identification");
      hread(BMC_OFF_ROM_HEADER, v, e);
      chk(v, BMC_RST_ROM_HEADER, "rom header reset");
      hread(8'h24, v, e);
      chk(e, 1, "unmapped offset");
      for (i = 0; i < 4; i++) rdres(i[1:0]);
      bus(BMC_TC_QREAD, BMC_CSR_BUS_INFO, 0, 0, 0, BMC_ACK_PENDING, BMC_BUS_IDENT_VALUE, 1, 0);
      v = $random(seed);
      hwrite(BMC_OFF_ROM_HEADER, v);
      bus(BMC_TC_QREAD, BMC_CSR_ROM_BASE, 0, 0, 0, BMC_ACK_PENDING, v, 1, 0);
      bus(BMC_TC_QREAD, 32'hF000_0408, 0, 0, 0, BMC_ACK_PENDING, 32'hC3C3C302, 1, 0);
      bus(BMC_TC_QREAD, BMC_CSR_ROM_LAST, 0, 0, 0, BMC_ACK_PENDING, 32'hC3C3C3FF, 1, 0);
      bus(4'h0, BMC_CSR_RES_BASE, 0, 32'h0, 0, BMC_ACK_TYPE_ERROR, 0, 0, 0);
      bus(BMC_TC_QREAD, 32'hF000_021E, 0, 0, 0, BMC_ACK_ADDR_ERROR, 0, 0, 0);
      rdres(0);
      for (i = 0; i < 8; i++) hswap(i[1:0], $random(seed), i[2] ? mres[i[1:0]] : $random(seed));
      for (i = 0; i < 8; i++) begin
         ev = i[2] ? mres[i[1:0]] : ~mres[i[1:0]];
         nv = $random(seed);
         bus(BMC_TC_LOCK, BMC_CSR_RES_BASE + {i[1:0], 2'b00}, ev, nv, i[0] ? 4'hB : 4'h1,
            BMC_ACK_PENDING, mres[i[1:0]], 1, i[0]);
         if (mres[i[1:0]] === ev) mres[i[1:0]] = nv;
         rdres(i[1:0]);
      end
      // bus reset reloads the resources but leaves host registers alone
      @(posedge CLK_SYS_IN);
      BUS_RESET_IN <= 1'b1;
      repeat (4) @(posedge CLK_SYS_IN);
      BUS_RESET_IN <= 1'b0;
      repeat (4) @(posedge CLK_SYS_IN);
      mres = '{BMC_RST_BUS_MGR_ID, BMC_RST_BANDWIDTH, BMC_RST_CHANNELS, BMC_RST_CHANNELS};
      for (i = 0; i < 4; i++) rdres(i[1:0]);
      hread(BMC_OFF_SWAP_DATA, v, e);
      chk(v, mdata, "host data kept");
      give_verdict();
   end
endmodule : testbench
